/* remark_pkg.sv */
package remark_pkg;

   // --------------------------------------------------------------
   // register indices on the plain management port
   // --------------------------------------------------------------
   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 32;
   localparam logic [7:0]  REG_PORT0   = 8'h00;
   localparam logic [7:0]  REG_GLOBAL  = 8'h40;
   localparam logic [7:0]  REG_CMAP    = 8'h41;
   localparam logic [7:0]  REG_STAT    = 8'h42;

   // --------------------------------------------------------------
   // per-port and global register field positions
   // --------------------------------------------------------------
   localparam int          F_DEFPRI    = 0;
   localparam int          F_GMRP      = 3;
   localparam int          F_MODE      = 4;
   localparam int          F_SUB       = 6;
   localparam int          F_DSCP      = 8;
   localparam int          F_PREC      = 16;
   localparam int          F_GLB_GMRP  = 0;

   // --------------------------------------------------------------
   // reset values
   // --------------------------------------------------------------
   localparam logic [2:0]  DEFPRI_RST  = 3'h0;
   localparam logic [15:0] CMAP_RST    = 16'hFA50;

   // --------------------------------------------------------------
   // differentiated-services modes and sub-modes
   // --------------------------------------------------------------
   localparam logic [1:0]  DS_OFF      = 2'h0;
   localparam logic [1:0]  DS_DSCP     = 2'h1;
   localparam logic [1:0]  DS_PREC     = 2'h2;
   localparam logic [1:0]  SUB_IFZERO  = 2'h0;
   localparam logic [1:0]  SUB_FORCE   = 2'h1;
   localparam logic [1:0]  SUB_P2T     = 2'h2;
   localparam logic [1:0]  SUB_T2P     = 2'h3;

   typedef struct packed {
      logic [2:0] prec_value;
      logic [5:0] dscp_value;
      logic [1:0] sub_mode;
      logic [1:0] ds_mode;
      logic       gmrp_en;
      logic [2:0] def_prio;
   } port_cfg_t;

endpackage

/* ingress_priority_remarker.sv */
// Function
// - each port holds a default priority, reset zero, given to unprioritised packets
// - each of eight priorities maps to a class 0..3 choosing the queue
// - each port has its own multicast-registration enable
// - a port enable counts only while the global enable is set
// - precedence is the top three bits of the service byte, written back there
// - per port: no rewrite, code-point mode or precedence mode
// - code-point force: every IPv4 packet gets the configured code point
// - code-point if-zero: replace only when received code point is zero
// - precedence force: every IPv4 packet gets the configured precedence
// - precedence-to-tag: copy IP precedence into the tag priority
// - after that copy the new priority selects the queue
// - tag-to-precedence: copy tag priority into the IP precedence
// - replacement code point per port ranges 0..63
// - replacement precedence per port ranges 0..7
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------------
// descriptor fifo
// ------------------------------------------------------------------
module desc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             core_clk_i, // clock
   input  wire logic             rst_i,      // async reset
   input  wire logic             in_valid_i, // push request
   output logic                  in_ready_o, // room for a word
   input  wire logic [WIDTH-1:0] in_data_i,  // pushed word
   output logic                  out_valid_o,// word at head
   input  wire logic             out_ready_i,// pop request
   output logic [WIDTH-1:0]      out_data_o  // head word
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wptr;
      logic [AW-1:0]               rptr;
      logic [AW:0]                 cnt;
      logic                        rdy;
      logic                        vld;
   } fifo_t;

   fifo_t q_ff;
   fifo_t nxt_q;

   logic  push;
   logic  pop;

   // ready and valid are kept as flops so that both stay honest
   // without a combinational path through the count
   always_comb begin
      nxt_q = q_ff;
      push  = in_valid_i & q_ff.rdy;
      pop   = out_ready_i & q_ff.vld;
      if (push) begin
         nxt_q.mem[q_ff.wptr] = in_data_i;
         nxt_q.wptr = q_ff.wptr + 1'b1;
      end
      if (pop) begin
         nxt_q.rptr = q_ff.rptr + 1'b1;
      end
      if (push && !pop) begin
         nxt_q.cnt = q_ff.cnt + 1'b1;
      end else if (pop && !push) begin
         nxt_q.cnt = q_ff.cnt - 1'b1;
      end
      nxt_q.rdy = (nxt_q.cnt != (AW+1)'(DEPTH));
      nxt_q.vld = (nxt_q.cnt != '0);
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q_ff     <= '0;
         q_ff.rdy <= 1'b1;
      end else begin
         q_ff     <= nxt_q;
      end
   end

   assign in_ready_o  = q_ff.rdy;
   assign out_valid_o = q_ff.vld;
   assign out_data_o  = q_ff.mem[q_ff.rptr];

endmodule

// ------------------------------------------------------------------
// ingress priority remarker
// ------------------------------------------------------------------
module ingress_priority_remarker
   import remark_pkg::*;
#(
   parameter int NUM_PORTS  = 26,
   parameter int PORT_W     = 5,
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic              core_clk_i,  // 20 MHz clock
   input  wire logic              rst_i,       // async reset, high
   input  wire logic [ADDR_W-1:0] reg_addr_i,  // register index
   input  wire logic [DATA_W-1:0] reg_wdata_i, // write data
   input  wire logic              reg_wr_i,    // write strobe
   input  wire logic              reg_rd_i,    // read strobe
   output logic [DATA_W-1:0]      reg_rdata_o, // read data, next cycle
   input  wire logic              pkt_valid_i, // descriptor offered
   output logic                   pkt_ready_o, // descriptor taken
   input  wire logic [PORT_W-1:0] pkt_port_i,  // receive port
   input  wire logic              pkt_ipv4_i,  // packet is IPv4
   input  wire logic              pkt_tagged_i,// packet has a priority
   input  wire logic [2:0]        pkt_prio_i,  // received tag priority
   input  wire logic [7:0]        pkt_tos_i,   // received service byte
   input  wire logic [15:0]       pkt_csum_i,  // received header checksum
   output logic                   out_valid_o, // result valid
   input  wire logic              out_ready_i, // queue logic accepts
   output logic [PORT_W-1:0]      out_port_o,  // receive port
   output logic                   out_ipv4_o,  // packet is IPv4
   output logic                   out_tagged_o,// packet had a tag
   output logic [2:0]             out_prio_o,  // final priority
   output logic [1:0]             out_class_o, // queue class 0..3
   output logic [7:0]             out_tos_o,   // final service byte
   output logic [15:0]            out_csum_o,  // final checksum
   output logic                   out_gmrp_o   // registration active
);

   localparam int PW = PORT_W + 2 + 3 + 8 + 16;

   typedef struct packed {
      port_cfg_t [NUM_PORTS-1:0] cfg;
      logic                      gmrp_glob;
      logic [15:0]               cmap;
      logic [DATA_W-1:0]         rdata;
      logic                      o_valid;
      logic [PORT_W-1:0]         o_port;
      logic                      o_ipv4;
      logic                      o_tagged;
      logic [2:0]                o_prio;
      logic [1:0]                o_class;
      logic [7:0]                o_tos;
      logic [15:0]               o_csum;
      logic                      o_gmrp;
      logic [15:0]               pkt_cnt;
      logic [15:0]               rew_cnt;
   } state_t;

   state_t q_ff;
   state_t nxt_q;

   // ---------------------------------------------------------------
   // descriptor buffer
   // ---------------------------------------------------------------
   logic          h_valid;
   logic          h_take;
   logic [PW-1:0] h_word;

   desc_fifo #(
      .WIDTH (PW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (pkt_valid_i),
      .in_ready_o  (pkt_ready_o),
      .in_data_i   ({pkt_port_i, pkt_ipv4_i, pkt_tagged_i,
                     pkt_prio_i, pkt_tos_i, pkt_csum_i}),
      .out_valid_o (h_valid),
      .out_ready_i (h_take),
      .out_data_o  (h_word)
   );

   // a stalled queue stops the output stage, which stops the pops
   assign h_take = h_valid & (~q_ff.o_valid | out_ready_i);

   // ---------------------------------------------------------------
   // one's-complement helper for incremental checksum update
   // ---------------------------------------------------------------
   function automatic logic [15:0] oc_add(input logic [15:0] a,
                                          input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[15:0] + {15'h0, s[16]};
   endfunction

   // ---------------------------------------------------------------
   // classification and rewrite of the head descriptor
   // ---------------------------------------------------------------
   logic [PORT_W-1:0] h_port;
   logic              h_ipv4;
   logic              h_tagged;
   logic [2:0]        h_prio;
   logic [7:0]        h_tos;
   logic [15:0]       h_csum;
   port_cfg_t         c;
   logic [2:0]        prio;
   logic [2:0]        new_prio;
   logic [7:0]        new_tos;
   logic [1:0]        new_class;
   logic [15:0]       new_csum;

   assign {h_port, h_ipv4, h_tagged, h_prio, h_tos, h_csum} = h_word;

   always_comb begin
      // out-of-range ports behave as a port at reset defaults
      c = '0;
      if (int'(h_port) < NUM_PORTS) begin
         c = q_ff.cfg[h_port];
      end
      prio     = h_tagged ? h_prio : c.def_prio;
      new_prio = prio;
      new_tos  = h_tos;
      if (h_ipv4) begin
         unique case (c.ds_mode)
            DS_DSCP: begin
               if (c.sub_mode == SUB_FORCE) begin
                  new_tos[7:2] = c.dscp_value;
               end else if (c.sub_mode == SUB_IFZERO &&
                            h_tos[7:2] == 6'h00) begin
                  new_tos[7:2] = c.dscp_value;
               end
            end
            DS_PREC: begin
               unique case (c.sub_mode)
                  SUB_FORCE:
                     new_tos[7:5] = c.prec_value;
                  SUB_P2T:
                     new_prio = h_tos[7:5];
                  SUB_T2P:
                     new_tos[7:5] = prio;
                  default: ;
               endcase
            end
            default: ;
         endcase
      end
      // queue class follows the rewritten priority
      new_class = q_ff.cmap[{new_prio, 1'b0} +: 2];
      // incremental update: only the service byte of word 0 changes
      new_csum = h_csum;
      if (new_tos != h_tos) begin
         new_csum = ~oc_add(oc_add(~h_csum, {8'hFF, ~h_tos}),
                            {8'h00, new_tos});
      end
   end

   // ---------------------------------------------------------------
   // register port and output stage
   // ---------------------------------------------------------------
   always_comb begin
      nxt_q       = q_ff;
      nxt_q.rdata = '0;

      if (reg_wr_i) begin
         if (int'(reg_addr_i) < NUM_PORTS) begin
            nxt_q.cfg[reg_addr_i].def_prio =
               reg_wdata_i[F_DEFPRI +: 3];
            nxt_q.cfg[reg_addr_i].gmrp_en =
               reg_wdata_i[F_GMRP];
            nxt_q.cfg[reg_addr_i].ds_mode =
               reg_wdata_i[F_MODE +: 2];
            nxt_q.cfg[reg_addr_i].sub_mode =
               reg_wdata_i[F_SUB +: 2];
            nxt_q.cfg[reg_addr_i].dscp_value =
               reg_wdata_i[F_DSCP +: 6];
            nxt_q.cfg[reg_addr_i].prec_value =
               reg_wdata_i[F_PREC +: 3];
         end else if (reg_addr_i == REG_GLOBAL) begin
            nxt_q.gmrp_glob = reg_wdata_i[F_GLB_GMRP];
         end else if (reg_addr_i == REG_CMAP) begin
            nxt_q.cmap = reg_wdata_i[15:0];
         end
      end

      if (reg_rd_i) begin
         if (int'(reg_addr_i) < NUM_PORTS) begin
            nxt_q.rdata[F_DEFPRI +: 3] = q_ff.cfg[reg_addr_i].def_prio;
            nxt_q.rdata[F_GMRP]        = q_ff.cfg[reg_addr_i].gmrp_en;
            nxt_q.rdata[F_MODE +: 2]   = q_ff.cfg[reg_addr_i].ds_mode;
            nxt_q.rdata[F_SUB +: 2]    = q_ff.cfg[reg_addr_i].sub_mode;
            nxt_q.rdata[F_DSCP +: 6]   = q_ff.cfg[reg_addr_i].dscp_value;
            nxt_q.rdata[F_PREC +: 3]   = q_ff.cfg[reg_addr_i].prec_value;
         end else if (reg_addr_i == REG_GLOBAL) begin
            nxt_q.rdata[F_GLB_GMRP] = q_ff.gmrp_glob;
         end else if (reg_addr_i == REG_CMAP) begin
            nxt_q.rdata[15:0] = q_ff.cmap;
         end else if (reg_addr_i == REG_STAT) begin
            nxt_q.rdata = {q_ff.rew_cnt, q_ff.pkt_cnt};
         end
      end

      if (out_ready_i) begin
         nxt_q.o_valid = 1'b0;
      end
      if (h_take) begin
         nxt_q.o_valid  = 1'b1;
         nxt_q.o_port   = h_port;
         nxt_q.o_ipv4   = h_ipv4;
         nxt_q.o_tagged = h_tagged;
         nxt_q.o_prio   = new_prio;
         nxt_q.o_class  = new_class;
         nxt_q.o_tos    = new_tos;
         nxt_q.o_csum   = new_csum;
         nxt_q.o_gmrp   = c.gmrp_en & q_ff.gmrp_glob;
         nxt_q.pkt_cnt  = q_ff.pkt_cnt + 1'b1;
         if (new_tos != h_tos || new_prio != prio) begin
            nxt_q.rew_cnt = q_ff.rew_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q_ff      <= '0;
         q_ff.cmap <= CMAP_RST;
      end else begin
         q_ff      <= nxt_q;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign reg_rdata_o  = q_ff.rdata;
   assign out_valid_o  = q_ff.o_valid;
   assign out_port_o   = q_ff.o_port;
   assign out_ipv4_o   = q_ff.o_ipv4;
   assign out_tagged_o = q_ff.o_tagged;
   assign out_prio_o   = q_ff.o_prio;
   assign out_class_o  = q_ff.o_class;
   assign out_tos_o    = q_ff.o_tos;
   assign out_csum_o   = q_ff.o_csum;
   assign out_gmrp_o   = q_ff.o_gmrp;

endmodule

`default_nettype wire

/* remark_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module remark_chk
   import remark_pkg::*;
#(
   parameter int PORT_W = 5
) (
   input wire logic              core_clk_i,  // clock
   input wire logic              rst_i,       // reset
   input wire logic [ADDR_W-1:0] reg_addr_i,  // index
   input wire logic [DATA_W-1:0] reg_wdata_i, // wdata
   input wire logic              reg_wr_i,    // write
   input wire logic              reg_rd_i,    // read
   input wire logic [DATA_W-1:0] reg_rdata_o, // rdata
   input wire logic              pkt_valid_i, // offer
   input wire logic              pkt_ready_o, // room
   input wire logic              out_valid_o, // result
   input wire logic              out_ready_i, // accept
   input wire logic [PORT_W-1:0] out_port_o,  // port
   input wire logic [2:0]        out_prio_o,  // prio
   input wire logic [1:0]        out_class_o, // class
   input wire logic [7:0]        out_tos_o,   // byte
   input wire logic [15:0]       out_csum_o,  // csum
   input wire logic              out_gmrp_o   // gmrp
);
   typedef struct packed {
      logic [15:0] cmap;
      logic        glb;
      logic        pw;
      logic [5:0]  fly;
   } shadow_t;
   shadow_t sh_ff, nxt_sh;
   // shadow copy lets class and gmrp be judged per result
   always_comb begin
      nxt_sh = sh_ff;
      if (reg_wr_i && reg_addr_i == REG_CMAP) nxt_sh.cmap = reg_wdata_i[15:0];
      if (reg_wr_i && reg_addr_i == REG_GLOBAL) nxt_sh.glb = reg_wdata_i[0];
      if (reg_wr_i && reg_addr_i < 8'h1A) nxt_sh.pw = 1'b1;
      nxt_sh.fly = sh_ff.fly + 6'(pkt_valid_i & pkt_ready_o)
                 - 6'(out_valid_o & out_ready_i);
   end
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) sh_ff <= '{cmap: CMAP_RST, default: '0};
      else sh_ff <= nxt_sh;
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   a_read_idle: assert property (!reg_rd_i |=> reg_rdata_o == '0)
      else $error("read data outside its slot");
   a_unmapped_read: assert property (reg_rd_i && reg_addr_i inside
      {[8'h1A:8'h3F], [8'h43:8'hFF]} |=> reg_rdata_o == '0)
      else $error("unmapped read not zero");
   a_cmap_read: assert property (
      reg_rd_i && reg_addr_i == REG_CMAP
      |=> reg_rdata_o == {16'h0000, $past(sh_ff.cmap)})
      else $error("class map readback wrong");
   a_port_reset: assert property (
      reg_rd_i && reg_addr_i < 8'h1A && !sh_ff.pw |=> reg_rdata_o == '0)
      else $error("port config not zero after reset");
   a_field_width: assert property (
      reg_rd_i && reg_addr_i < 8'h1A |=> (reg_rdata_o & 32'hFFF8C000) == '0)
      else $error("port config has stray bits");
   a_class_map: assert property (
      out_valid_o |-> out_class_o == sh_ff.cmap[2*out_prio_o +: 2])
      else $error("class not from map");
   a_gmrp_global: assert property (
      out_valid_o && out_gmrp_o |-> sh_ff.glb)
      else $error("gmrp without global enable");
   a_out_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o
      && $stable({out_port_o, out_prio_o, out_tos_o, out_csum_o, out_gmrp_o}))
      else $error("result changed while stalled");
   a_no_phantom: assert property (out_valid_o |-> sh_ff.fly != 6'h00)
      else $error("result without a descriptor");
endmodule

bind ingress_priority_remarker remark_chk #(.PORT_W(PORT_W)) remark_chk_i (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .pkt_valid_i(pkt_valid_i),
   .pkt_ready_o(pkt_ready_o), .out_valid_o(out_valid_o),
   .out_ready_i(out_ready_i), .out_port_o(out_port_o),
   .out_prio_o(out_prio_o), .out_class_o(out_class_o),
   .out_tos_o(out_tos_o), .out_csum_o(out_csum_o), .out_gmrp_o(out_gmrp_o));
`default_nettype wire

/* queue_sink.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// queue logic model: accepts results, stalls on a pattern
// ------------------------------------------------------------
module queue_sink (
   input  wire logic core_clk_i, // clock
   input  wire logic rst_i,      // reset
   input  wire logic hold_i,     // stall fully
   input  wire logic fast_i,     // never stall unless held
   output logic      ready_o     // accept
);
   logic [7:0] lfsr_ff;
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lfsr_ff <= 8'hA5;
         ready_o <= 1'b0;
      end else begin
         lfsr_ff <= {lfsr_ff[6:0], ^(lfsr_ff & 8'hB8)};
         ready_o <= !hold_i && (fast_i || lfsr_ff[0]);
      end
   end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
   $display("BAD %0t mismatch got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
   import remark_pkg::*;
   logic clk, rst, wrs, rds, pv, tg, ip, hold, fast;
   logic [7:0] addr, tos;
   logic [31:0] wdata, cfg[0:31];
   logic [4:0] port;
   logic [2:0] pri;
   logic [15:0] cs, cmap;
   logic glb;
   wire logic [31:0] rdata;
   wire logic pr, ov, ordy, oip, otg, ogm;
   wire logic [4:0] oport;
   wire logic [2:0] opri;
   wire logic [1:0] ocls;
   wire logic [7:0] otos;
   wire logic [15:0] ocs;
   int num_errors, comparisons, seed, nrew, npkt;
   logic [36:0] expq[$];

   ingress_priority_remarker ingress_priority_remarker_i (
      .core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wrs), .reg_rd_i(rds), .reg_rdata_o(rdata), .pkt_valid_i(pv),
      .pkt_ready_o(pr), .pkt_port_i(port), .pkt_ipv4_i(ip),
      .pkt_tagged_i(tg), .pkt_prio_i(pri), .pkt_tos_i(tos), .pkt_csum_i(cs),
      .out_valid_o(ov), .out_ready_i(ordy), .out_port_o(oport),
      .out_ipv4_o(oip), .out_tagged_o(otg), .out_prio_o(opri),
      .out_class_o(ocls), .out_tos_o(otos), .out_csum_o(ocs),
      .out_gmrp_o(ogm));
   queue_sink queue_sink_i (.core_clk_i(clk), .rst_i(rst), .hold_i(hold),
      .fast_i(fast), .ready_o(ordy));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ---------------------------------------------------------
   // expected result of one descriptor
   // ---------------------------------------------------------
   function automatic logic [36:0] expect_out(input logic [4:0] p,
      input logic a, g, input logic [2:0] q, input logic [7:0] t,
      input logic [15:0] c);
      logic [31:0] w;
      logic [2:0] e;
      logic [7:0] n;
      logic [16:0] s;
      w = (p < 5'd26) ? cfg[p] : '0;
      e = g ? q : w[2:0];
      n = t;
      if (a && w[5:4] == DS_DSCP && (w[7:6] == SUB_FORCE ||
          (w[7:6] == SUB_IFZERO && t[7:2] == 6'h00))) n[7:2] = w[13:8];
      if (a && w[5:4] == DS_PREC) begin
         case (w[7:6])
            SUB_FORCE: n[7:5] = w[18:16];
            SUB_P2T: e = t[7:5];
            SUB_T2P: n[7:5] = e;
            default: ;
         endcase
      end
      // incremental one's complement update of the first header word
      // changed byte or priority is what the status counter tallies
      if (n != t || e != (g ? q : w[2:0])) nrew++;
      s = {1'b0, ~c} + {9'h0FF, ~t};
      s = {1'b0, s[15:0]} + 17'(s[16]);
      s = {1'b0, s[15:0]} + {9'h000, n};
      s = {1'b0, s[15:0]} + 17'(s[16]);
      return {p, a, g, e, cmap[2*e +: 2], n, (n != t) ? ~s[15:0] : c,
              w[3] & glb};
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wrs <= 1'b1;
      @(posedge clk);
      wrs <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      addr <= a;
      rds <= 1'b1;
      @(posedge clk);
      rds <= 1'b0;
      @(posedge clk);
      `CHK(rdata, e)
   endtask

   task automatic send();
      logic [7:0] t;
      t = 8'($random(seed));
      if (t[0]) t[7:2] = 6'h00;
      // mask reaches ports 24..27, so unconfigured indices are hit too
      port <= 5'($random(seed)) & 5'h1B;
      ip <= 1'($random(seed));
      tg <= 1'($random(seed));
      pri <= 3'($random(seed));
      cs <= 16'($random(seed));
      tos <= t;
      pv <= 1'b1;
      #1 expq.push_back(expect_out(port, ip, tg, pri, t, cs));
      npkt++;
      do @(posedge clk); while (pr !== 1'b1);
   endtask

   task automatic drain();
      int n;
      n = 0;
      while (expq.size() != 0 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      `CHK(expq.size(), 0)
   endtask

   task automatic conclude();
      $display("counts: errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   always @(posedge clk) begin
      if (!rst && ov === 1'b1 && ordy === 1'b1)
         `CHK({oport, oip, otg, opri, ocls, otos, ocs, ogm}, (expq.size() != 0) ? expq.pop_front() : 'x)
   end

   initial begin
      #1000000;
      num_errors++;
      conclude();
   end

   // ---------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------
   initial begin
      {wrs, rds, pv, tg, ip, hold, addr, tos, wdata, port, pri, cs} = '0;
      seed = 85;
      fast = 1'b1;
      rst = 1'b1;
      cmap = CMAP_RST;
      glb = 1'b0;
      for (int i = 0; i < 32; i++) cfg[i] = '0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(REG_CMAP, 32'h0000FA50);
      for (int p = 0; p < 26; p++) rd(8'(p), '0);
      rd(8'h50, '0);
      $display("reset values done");
      for (int r = 0; r < 24; r++) begin
         glb = 1'($random(seed));
         cmap = 16'($random(seed));
         wr(REG_GLOBAL, {31'h0, glb});
         wr(REG_CMAP, {16'h0, cmap});
         for (int p = 0; p < 4; p++) begin
            cfg[p] = 32'($random(seed)) & 32'h00073F0F;
            cfg[p][7:4] = 4'(r * 4 + p);
            wr(8'(p), cfg[p]);
            rd(8'(p), cfg[p]);
         end
         fast <= r[0];
         repeat (12) send();
         pv <= 1'b0;
         drain();
      end
      $display("rewrite rounds done");
      hold <= 1'b1;
      fork
         begin
            repeat (24) send();
            pv <= 1'b0;
         end
         begin
            repeat (40) @(posedge clk);
            `CHK(pr, 1'b0)
            hold <= 1'b0;
         end
      join
      drain();
      rd(REG_STAT, {16'(nrew), 16'(npkt)});
      $display("full buffer done");
      conclude();
   end
endmodule
`default_nettype wire
